// ---- pkg/plt_consts.svh ----
// Purpose: constants of the lock delay timer
// Assumes: 16-bit data memory space, one reference clock
// Notes: definitions only
`ifndef PLT_CONSTS_SVH
`define PLT_CONSTS_SVH

// ----------------------------------------
// register placement
// ----------------------------------------
`define PLT_ADDR_W 16
`define PLT_DATA_W 16
`define PLT_CLKMODE_ADDR 16'h0058

// ----------------------------------------
// field positions of clock_generator_mode
// ----------------------------------------
`define PLT_MUL_HI 15
`define PLT_MUL_LO 12
`define PLT_FRAC_BIT 11
`define PLT_PRESET_HI 10
`define PLT_PRESET_LO 3
`define PLT_VCO_ON_BIT 2
`define PLT_SEL_BIT 1
`define PLT_STATUS_BIT 0

// ----------------------------------------
// reset values
// ----------------------------------------
`define PLT_MUL_RST 4'hF
`define PLT_FRAC_RST 1'b0
`define PLT_PRESET_RST 8'h00
`define PLT_VCO_ON_RST 1'b0
`define PLT_SEL_RST 1'b1

// ----------------------------------------
// timing
// ----------------------------------------
`define PLT_REF_PER_TICK 16
`define PLT_PRESET_W 8

`endif

// ---- pkg/plt_pkg.sv ----
// Purpose: types of the lock delay timer
// Assumes: nothing
// Notes: constants live in plt_consts.svh
package plt_pkg;

    // ----------------------------------------
    // clock generator mode
    // ----------------------------------------
    typedef enum logic [1:0] {
        plt_st_div,
        plt_st_locking,
        plt_st_pll
    } plt_state_e;

endpackage : plt_pkg

// ---- pkg/plt_tick_if.sv ----
// Purpose: link between lock controller and reference prescaler
// Assumes: same clock on both sides
// Notes: clear restarts the divide-by-16 phase
`timescale 1ns/10ps
`default_nettype none

interface plt_tick_if;
    logic clear;
    logic tick;

    modport ctrl (output clear, input tick);
    modport presc (input clear, output tick);
endinterface : plt_tick_if

`default_nettype wire

// ---- verilog/plt_prescaler.sv ----
// Purpose: divides the reference clock by a fixed ratio into a tick
// Assumes: clear comes from logic on the same clock
// Notes: tick is high on the last cycle of each period
`timescale 1ns/10ps
`default_nettype none

`include "plt_consts.svh"

module plt_prescaler import plt_pkg::*; #(
    parameter int RATIO = `PLT_REF_PER_TICK
) (
    input wire logic clock_i,
    input wire logic srst_i,
    plt_tick_if.presc link
);

    localparam int CW = $clog2(RATIO);
    localparam logic [CW-1:0] LAST = CW'(RATIO - 1);

    logic [CW-1:0] phase;

    // ----------------------------------------
    // phase counter
    // ----------------------------------------
    assign link.tick = (phase == LAST);

    always_ff @(posedge clock_i) begin
        if (srst_i || link.clear) begin
            phase <= '0;
        end else begin
            phase <= phase + CW'(1);
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_tick_period;
        @(posedge clock_i) disable iff (srst_i || link.clear)
        link.tick |=> !link.tick [*8] ##1 !link.tick [*7] ##1 link.tick;
    endproperty
    a_tick_period: assert property (p_tick_period) else $error("tick period is not 16");

endmodule : plt_prescaler

`default_nettype wire

// ---- verilog/plt_lock_timer.sv ----
// Purpose: lock delay timer and mode control of the clock generator
// Assumes: clock_i is the input reference clock; bus signals share it
// Notes: register read data appears one cycle after the read strobe
//
// Operation
// - preset loads a down-counter that stops at zero
// - preset spans 0 to 255, eight bits
// - one decrement per 16 reference cycles
// - divide to PLL switch loads and starts
// - core stays on divide clock while counting
// - core moves to PLL at zero
// - mode register sits at address 58h
// - preset held in bits 10 to 3
// - select bit high PLL, low divide
// - status bit reads one in PLL mode
// - reset gives bypass PLL mode, multiplier 15
`timescale 1ns/10ps
`default_nettype none

`include "plt_consts.svh"

module plt_lock_timer import plt_pkg::*; #(
    parameter int PRESET_W = `PLT_PRESET_W,
    parameter int REF_PER_TICK = `PLT_REF_PER_TICK
) (
    input wire logic clock_i,
    input wire logic srst_i,
    input wire logic [`PLT_ADDR_W-1:0] addr_i,
    input wire logic wr_en_i,
    input wire logic rd_en_i,
    input wire logic [`PLT_DATA_W-1:0] wdata_i,
    output logic [`PLT_DATA_W-1:0] rdata_o,
    output logic core_src_pll_o,
    output logic lock_busy_o,
    output logic vco_on_o,
    output logic [3:0] multiplier_field_o,
    output logic fractional_select_o
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    plt_state_e state;
    plt_state_e next_state;
    logic [PRESET_W-1:0] lock_count_preset;
    logic [PRESET_W-1:0] timer;
    logic [PRESET_W-1:0] next_timer;
    logic vco_on_bit;
    logic pll_select_bit;

    plt_tick_if tick_link ();

    // ----------------------------------------
    // decode
    // ----------------------------------------
    wire sel = (addr_i == `PLT_CLKMODE_ADDR);
    wire wr = wr_en_i && sel;
    wire rd = rd_en_i && sel;
    wire new_sel = wdata_i[`PLT_SEL_BIT];
    wire [PRESET_W-1:0] new_preset = wdata_i[`PLT_PRESET_HI:`PLT_PRESET_LO];
    wire start_lock = wr && new_sel && (state == plt_st_div);
    wire leave_pll = wr && !new_sel;
    wire last_tick = (state == plt_st_locking) && tick_link.tick && (timer == PRESET_W'(1));
    wire status_bit = (state == plt_st_pll);
    wire [`PLT_DATA_W-1:0] read_word = {multiplier_field_o, fractional_select_o, lock_count_preset,
                                        vco_on_bit, pll_select_bit, status_bit};

    assign tick_link.clear = start_lock;

    // ----------------------------------------
    // reference prescaler
    // ----------------------------------------
    plt_prescaler #(
        .RATIO(REF_PER_TICK)
    ) u_prescaler (
        .clock_i(clock_i),
        .srst_i(srst_i),
        .link(tick_link)
    );

    // ----------------------------------------
    // mode sequencing
    // ----------------------------------------
    always_comb begin
        next_state = state;
        next_timer = timer;
        case (state)
            plt_st_div: begin
                if (start_lock) begin
                    if (new_preset == '0) begin
                        next_state = plt_st_pll;
                    end else begin
                        next_state = plt_st_locking;
                        next_timer = new_preset;
                    end
                end
            end
            plt_st_locking: begin
                if (leave_pll) begin
                    next_state = plt_st_div;
                    next_timer = '0;
                end else if (tick_link.tick) begin
                    next_timer = timer - PRESET_W'(1);
                    if (last_tick) begin
                        next_state = plt_st_pll;
                    end
                end
            end
            plt_st_pll: begin
                if (leave_pll) begin
                    next_state = plt_st_div;
                end
            end
            default: begin
                next_state = plt_st_div;
                next_timer = '0;
            end
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            state <= plt_st_pll;
            timer <= '0;
            core_src_pll_o <= 1'b1;
            lock_busy_o <= 1'b0;
        end else begin
            state <= next_state;
            timer <= next_timer;
            core_src_pll_o <= (next_state == plt_st_pll);
            lock_busy_o <= (next_state == plt_st_locking);
        end
    end

    // ----------------------------------------
    // clock_generator_mode register
    // ----------------------------------------
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            multiplier_field_o <= `PLT_MUL_RST;
            fractional_select_o <= `PLT_FRAC_RST;
            lock_count_preset <= `PLT_PRESET_RST;
            vco_on_bit <= `PLT_VCO_ON_RST;
            pll_select_bit <= `PLT_SEL_RST;
        end else if (wr) begin
            multiplier_field_o <= wdata_i[`PLT_MUL_HI:`PLT_MUL_LO];
            fractional_select_o <= wdata_i[`PLT_FRAC_BIT];
            lock_count_preset <= new_preset;
            vco_on_bit <= wdata_i[`PLT_VCO_ON_BIT];
            pll_select_bit <= new_sel;
        end
    end

    // ----------------------------------------
    // read data and oscillator enable
    // ----------------------------------------
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            rdata_o <= '0;
            vco_on_o <= 1'b1;
        end else begin
            rdata_o <= rd ? read_word : '0;
            vco_on_o <= wr ? (wdata_i[`PLT_VCO_ON_BIT] | new_sel) : (vco_on_bit | pll_select_bit);
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (srst_i);

    property p_load;
        start_lock && (new_preset != '0) |=> (state == plt_st_locking) && (timer == $past(new_preset));
    endproperty
    a_load: assert property (p_load) else $error("timer not loaded on mode switch");

    property p_hold;
        (state == plt_st_locking) && !tick_link.tick && !wr |=> (timer == $past(timer));
    endproperty
    a_hold: assert property (p_hold) else $error("timer moved between ticks");

    property p_decrement;
        (state == plt_st_locking) && tick_link.tick && !wr && (timer > PRESET_W'(1))
            |=> (state == plt_st_locking) && (timer == $past(timer) - PRESET_W'(1));
    endproperty
    a_decrement: assert property (p_decrement) else $error("timer did not step down by one");

    property p_divide_clock;
        (state == plt_st_locking) |-> !core_src_pll_o && lock_busy_o;
    endproperty
    a_divide_clock: assert property (p_divide_clock) else $error("PLL clock passed during lock");

    property p_switch;
        last_tick && !wr |=> core_src_pll_o ##1 core_src_pll_o;
    endproperty
    a_switch: assert property (p_switch) else $error("no handover at zero");

    property p_zero_preset;
        start_lock && (new_preset == '0) |=> core_src_pll_o && !lock_busy_o;
    endproperty
    a_zero_preset: assert property (p_zero_preset) else $error("zero preset delayed handover");

    property p_divide_write;
        leave_pll |=> (state == plt_st_div) && !core_src_pll_o;
    endproperty
    a_divide_write: assert property (p_divide_write) else $error("divide mode not entered");

    property p_status;
        rd |=> rdata_o[`PLT_STATUS_BIT] == $past(status_bit);
    endproperty
    a_status: assert property (p_status) else $error("status bit wrong");

    property p_other_addr;
        wr_en_i && !sel |=> $stable(lock_count_preset) && $stable(pll_select_bit);
    endproperty
    a_other_addr: assert property (p_other_addr) else $error("write at foreign address took effect");

    property p_preset_field;
        wr |=> lock_count_preset == $past(wdata_i[`PLT_PRESET_HI:`PLT_PRESET_LO]);
    endproperty
    a_preset_field: assert property (p_preset_field) else $error("preset not taken from bits 10..3");

    property p_after_reset;
        $fell(srst_i) |-> (multiplier_field_o == `PLT_MUL_RST) && core_src_pll_o && !fractional_select_o;
    endproperty
    a_after_reset: assert property (p_after_reset) else $error("reset mode is not bypass");

endmodule : plt_lock_timer

`default_nettype wire

// ---- test/plt_lock_timer_tb.sv ----
// Purpose: self-checking bench of the lock delay timer
// Assumes: register reached by single-cycle read and write strobes
// Notes: full-size preset and divider, longest lock 4080 cycles
`timescale 1ns/10ps
`default_nettype none

`include "plt_consts.svh"

`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("Error at %0t: got %h expected %h", $time, got, exp); end end

module plt_lock_timer_tb;
    import plt_pkg::*;

    logic clock_i;
    logic srst_i;
    logic [15:0] addr_i;
    logic wr_en_i;
    logic rd_en_i;
    logic [15:0] wdata_i;
    logic [15:0] rdata_o;
    logic core_src_pll_o;
    logic lock_busy_o;
    logic vco_on_o;
    logic [3:0] multiplier_field_o;
    logic fractional_select_o;
    int n_mismatch = 0;
    int compares = 0;

    plt_lock_timer #(.PRESET_W(8), .REF_PER_TICK(16)) i_dut (
        .clock_i(clock_i),
        .srst_i(srst_i),
        .addr_i(addr_i),
        .wr_en_i(wr_en_i),
        .rd_en_i(rd_en_i),
        .wdata_i(wdata_i),
        .rdata_o(rdata_o),
        .core_src_pll_o(core_src_pll_o),
        .lock_busy_o(lock_busy_o),
        .vco_on_o(vco_on_o),
        .multiplier_field_o(multiplier_field_o),
        .fractional_select_o(fractional_select_o)
    );

    // ----------------------------------------
    // clock and watchdog
    // ----------------------------------------
    initial begin
        clock_i = 1'b0;
        forever #25 clock_i = ~clock_i;
    end

    initial begin
        repeat (20000) @(posedge clock_i);
        n_mismatch++;
        print_verdict();
    end

    // ----------------------------------------
    // access tasks
    // ----------------------------------------
    task automatic wr(input logic [15:0] d, input logic [15:0] a = `PLT_CLKMODE_ADDR);
        @(posedge clock_i);
        #1 wr_en_i = 1'b1;
        addr_i = a;
        wdata_i = d;
        @(posedge clock_i);
        #1 wr_en_i = 1'b0;
    endtask : wr

    task automatic rd(input logic [15:0] exp, input logic [15:0] a = `PLT_CLKMODE_ADDR);
        @(posedge clock_i);
        #1 rd_en_i = 1'b1;
        addr_i = a;
        @(posedge clock_i);
        #1 rd_en_i = 1'b0;
        `CHK(rdata_o, exp)
    endtask : rd

    task automatic do_reset();
        srst_i = 1'b1;
        repeat (16) @(posedge clock_i);
        #1 srst_i = 1'b0;
    endtask : do_reset

    // from divide mode, start a lock and follow it to the hand-over
    task automatic lock(input logic [7:0] n);
        wr({4'hF, 1'b0, n, 3'b010});
        if (n == 8'h00) begin
            `CHK(core_src_pll_o, 1'b1)
            `CHK(lock_busy_o, 1'b0)
        end else begin
            `CHK(lock_busy_o, 1'b1)
            `CHK(core_src_pll_o, 1'b0)
            repeat (16 * int'(n) - 1) @(posedge clock_i);
            #1 `CHK(core_src_pll_o, 1'b0)
            @(posedge clock_i);
            #1 `CHK(core_src_pll_o, 1'b1)
            `CHK(lock_busy_o, 1'b0)
        end
        rd({4'hF, 1'b0, n, 3'b011});
    endtask : lock

    task automatic print_verdict();
        if (n_mismatch == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : print_verdict

    // ----------------------------------------
    // test sequence
    // ----------------------------------------
    initial begin
        srst_i = 1'b1;
        addr_i = 16'h0000;
        wr_en_i = 1'b0;
        rd_en_i = 1'b0;
        wdata_i = 16'h0000;
        #1 do_reset();
        // reset state: bypass PLL mode
        `CHK(core_src_pll_o, 1'b1)
        `CHK(multiplier_field_o, 4'hF)
        `CHK(fractional_select_o, 1'b0)
        `CHK(vco_on_o, 1'b1)
        rd(16'hF003);
        rd(16'h0000, 16'h0059);
        // divide mode, status read-only
        wr(16'h0001);
        `CHK(core_src_pll_o, 1'b0)
        rd(16'h0000);
        `CHK(vco_on_o, 1'b0)
        wr(16'h5804);
        @(posedge clock_i);
        #1 `CHK(vco_on_o, 1'b1)
        `CHK(multiplier_field_o, 4'h5)
        `CHK(fractional_select_o, 1'b1)
        rd(16'h5804);
        // locks at the boundary presets
        lock(8'h01);
        wr(16'hF000);
        lock(8'hFF);
        wr(16'hF000);
        // preset for a 16 us lock time at a 50 ns reference period
        lock(8'(16000 / (16 * 50)));
        wr(16'hF000);
        lock(8'h00);
        // select rewritten in PLL mode does not restart
        wr(16'hF082);
        `CHK(lock_busy_o, 1'b0)
        `CHK(core_src_pll_o, 1'b1)
        // writes elsewhere leave the register alone
        wr(16'h0000, 16'h0057);
        rd(16'hF083);
        // select rewritten during a lock does not restart it
        wr(16'hF000);
        wr(16'hF012);
        wr(16'hF0FA);
        repeat (29) @(posedge clock_i);
        #1 `CHK(core_src_pll_o, 1'b0)
        @(posedge clock_i);
        #1 `CHK(core_src_pll_o, 1'b1)
        // abort of a running lock
        wr(16'hF000);
        wr(16'hF02A);
        repeat (10) @(posedge clock_i);
        wr(16'hF028);
        `CHK(core_src_pll_o, 1'b0)
        `CHK(lock_busy_o, 1'b0)
        repeat (100) @(posedge clock_i);
        #1 `CHK(core_src_pll_o, 1'b0)
        // second reset in mid-run
        wr(16'hF02A);
        repeat (5) @(posedge clock_i);
        #1 do_reset();
        `CHK(lock_busy_o, 1'b0)
        rd(16'hF003);
        print_verdict();
    end
endmodule : plt_lock_timer_tb

`undef CHK
`default_nettype wire
